/* core/gbc_breaker_ctrl.sv */
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module gbc_tick_cnt (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       run_in,
    input  wire logic       tick_in,
    output logic [7:0]      cnt_out
);
    // Saturating tick counter, cleared while not running
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !run_in) begin
            cnt_out <= 8'h00;
        end else if (tick_in && cnt_out != 8'hff) begin
            cnt_out <= cnt_out + 8'h01;
        end
    end
endmodule

module gbc_breaker_ctrl #(
    parameter int unsigned TICK_CYCLES = gbc_pkg::TICK_CYC
) (
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [11:0]       paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              gen_closed_in,
    input  wire logic              mains_closed_in,
    input  wire logic              gen_ok_in,
    input  wire logic              mains_ok_in,
    input  wire logic              gen_sync_request_in,
    input  wire logic              mains_sync_request_in,
    input  wire logic              sync_done_in,
    input  wire logic              mains_closure_inhibit_in,
    input  wire logic              gen_closure_inhibit_in,
    input  wire logic              start_request_in,
    input  wire logic              alarm_active_in,
    input  wire logic              self_started_in,
    input  wire logic              gen_external_control_in,
    input  wire logic              mains_external_control_in,
    input  wire gbc_pkg::gbc_man_t man_in,
    input  wire logic              immediate_supply_in,
    input  wire logic              more_gens_in,
    input  wire logic [14:0]       bus_power_in,
    output logic                   gen_steady_close_out,
    output logic                   mains_steady_close_out,
    output logic                   gen_mv_coil_out,
    output logic                   mains_mv_coil_out,
    output logic                   gen_sync_active_out,
    output logic                   mains_sync_active_out,
    output logic                   transfer_close_out,
    output logic                   mains_switch_open_out
);
    import gbc_pkg::*;

    gbc_ctrl_t   ctrl_q;
    logic [15:0] times_q;
    logic [14:0] min_pwr_q;
    logic [7:0]  cmd_q;
    logic        cmd_v_q;
    logic [23:0] pre_q;
    logic        tick_q;
    gbc_mode_t   mode_prev_q;
    gbc_man_t    man_q;
    logic        gen_tgt_q, gen_tgt_d, mains_tgt_q, mains_tgt_d;
    logic        gen_steady_d, mains_steady_d, protect_q;
    logic [7:0]  mv_g_cnt, mv_m_cnt, both_cnt, hold_cnt, mopen_cnt;

    // APB decode, one wait state then answer
    wire acc      = psel_in && penable_in;
    wire done     = acc && pready_out;
    wire wr       = done && pwrite_in;
    wire hit_ctrl = paddr_in == REG_CTRL;
    wire hit_tim  = paddr_in == REG_TIMES;
    wire hit_pwr  = paddr_in == REG_BUSPWR;
    wire hit_cmd  = paddr_in == REG_CMD;
    wire hit_stat = paddr_in == REG_STATUS;
    wire mapped   = hit_ctrl || hit_tim || hit_pwr || hit_cmd || hit_stat;
    wire [31:0] status_w = {22'h0, mv_m_cnt >= MV_TICKS, mv_g_cnt >= MV_TICKS,
                            mains_tgt_q, gen_tgt_q, mains_sync_active_out,
                            gen_sync_active_out, mains_steady_close_out,
                            gen_steady_close_out, mains_closed_in, gen_closed_in};
    wire [31:0] rd_w = hit_ctrl ? {20'h0, ctrl_q} :
                       hit_tim  ? {16'h0, times_q} :
                       hit_pwr  ? {17'h0, min_pwr_q} :
                       hit_stat ? status_w : 32'h0;

    // Bus slave and configuration registers
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
            ctrl_q      <= CTRL_RST;
            times_q     <= TIMES_RST;
            min_pwr_q   <= BUSPWR_RST;
            cmd_q       <= 8'h00;
            cmd_v_q     <= 1'b0;
        end else begin
            pready_out  <= acc && !pready_out;
            pslverr_out <= acc && !pready_out && !mapped;
            prdata_out  <= (acc && !pready_out && !pwrite_in) ? rd_w : 32'h0;
            cmd_v_q     <= wr && hit_cmd;
            if (wr && hit_ctrl) ctrl_q <= gbc_ctrl_t'(pwdata_in[11:0]);
            if (wr && hit_tim) times_q <= pwdata_in[15:0];
            if (wr && hit_pwr) min_pwr_q <= (pwdata_in[14:0] > BUSPWR_MAX) ? BUSPWR_MAX
                                                                            : pwdata_in[14:0];
            if (wr && hit_cmd) cmd_q <= pwdata_in[7:0];
        end
    end

    // Shared prescaler for all second-scale timers
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pre_q  <= 24'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= pre_q == 24'(TICK_CYCLES - 1);
            pre_q  <= (pre_q == 24'(TICK_CYCLES - 1)) ? 24'h0 : pre_q + 24'h1;
        end
    end

    // Mode, manual edges and derived conditions
    wire is_off    = ctrl_q.mode == MODE_OFF;
    wire is_man    = ctrl_q.mode == MODE_MAN;
    wire is_auto   = ctrl_q.mode == MODE_AUTO;
    wire auto2man  = is_man && mode_prev_q == MODE_AUTO;
    wire gbc_man_t rise = man_in & ~man_q;
    wire rmt       = cmd_v_q && is_man;
    wire [7:0] swap_t = times_q[TIMES_SWAP_LSB +: 8];
    wire [7:0] hold_t = times_q[TIMES_HOLD_LSB +: 8];
    wire gen_ext   = gen_external_control_in;
    wire mains_ext = mains_external_control_in;
    wire gen_close_ok = !alarm_active_in && self_started_in && gen_ok_in;
    wire mains_close_ok = mains_ok_in ||
                          !(ctrl_q.mains_coil_powered || ctrl_q.mains_timing_sel);
    wire mains_protect  = ctrl_q.mains_timing_sel && !mains_ok_in;
    wire mopen_acc = tick_q && man_in.mains_open && ctrl_q.man_open_cfg_mains &&
                     mopen_cnt == PERSIST_TICKS - 8'h01;
    wire gen_open_req = rmt && (cmd_q == CMD_GEN_OPEN_NOW || cmd_q == CMD_GEN_OPEN_UNLOAD) ||
                        (rise.gen_open && ctrl_q.man_open_cfg_gen) ||
                        (rise.gen_close && !ctrl_q.man_open_cfg_gen && gen_tgt_q);
    wire gen_close_req = rmt && cmd_q == CMD_GEN_CLOSE ||
                         (rise.gen_close && (ctrl_q.man_open_cfg_gen || !gen_tgt_q));
    wire mains_open_req = rmt && (cmd_q == CMD_MAINS_OPEN_A || cmd_q == CMD_MAINS_OPEN_B) ||
                          mopen_acc ||
                          (rise.mains_close && !ctrl_q.man_open_cfg_mains && mains_tgt_q);
    wire mains_close_req = rmt && cmd_q == CMD_MAINS_CLOSE ||
                           (rise.mains_close && (ctrl_q.man_open_cfg_mains || !mains_tgt_q));
    wire auto_mains_open = mains_closure_inhibit_in ||
                           (!ctrl_q.parallel_plant && gen_tgt_q) ||
                           (ctrl_q.parallel_plant && !mains_ok_in &&
                            ctrl_q.mains_interface);

    // Synchronization windows and closing interlocks
    wire gen_sync_w = gen_tgt_q && !gen_closed_in && ctrl_q.gen_use_sync &&
                      gen_sync_request_in && gen_ok_in && mains_ok_in && !gen_ext;
    wire mains_sync_w = mains_tgt_q && !mains_closed_in && ctrl_q.mains_use_sync &&
                        mains_sync_request_in && gen_ok_in && mains_ok_in && !mains_ext;
    wire both_open  = !gen_closed_in && !mains_closed_in;
    wire swap_done  = both_open && both_cnt >= swap_t;
    wire hold_ok    = !ctrl_q.commutator_en || hold_cnt >= hold_t;
    wire mains_yield = gen_tgt_q && !gen_closed_in && !ctrl_q.gen_use_sync;
    wire gen_may_close = mv_g_cnt >= MV_TICKS && (ctrl_q.commutator_en || swap_done ||
                         (gen_sync_active_out && sync_done_in));
    wire mains_may_close = mv_m_cnt >= MV_TICKS &&
                           (swap_done || (mains_sync_active_out && sync_done_in));

    // Generator breaker target
    always_comb begin
        gen_tgt_d = gen_tgt_q;
        if (gen_ext) begin
            gen_tgt_d = gen_closed_in;
        end else if (is_off) begin
            gen_tgt_d = 1'b0;
        end else if (is_auto) begin
            gen_tgt_d = start_request_in && !gen_closure_inhibit_in && gen_close_ok;
        end else if (auto2man) begin
            gen_tgt_d = ctrl_q.auto_man_open ? 1'b0 : gen_tgt_q;
        end else if (gen_open_req) begin
            gen_tgt_d = 1'b0;
        end else if (gen_close_req && gen_close_ok) begin
            gen_tgt_d = 1'b1;
        end
    end

    // Mains breaker target
    always_comb begin
        mains_tgt_d = mains_tgt_q;
        if (mains_ext) begin
            mains_tgt_d = mains_closed_in;
        end else if (mains_protect) begin
            mains_tgt_d = 1'b0;
        end else if (is_off) begin
            mains_tgt_d = mains_closed_in || mains_close_ok;
        end else if (is_auto) begin
            mains_tgt_d = !auto_mains_open && (mains_closed_in || mains_close_ok);
        end else if (mains_open_req) begin
            mains_tgt_d = 1'b0;
        end else if ((mains_close_req || protect_q) && mains_close_ok) begin
            mains_tgt_d = 1'b1;
        end
    end

    // Steady commands with interlocks
    always_comb begin
        gen_steady_d = gen_steady_close_out;
        if (gen_ext) begin
            gen_steady_d = gen_closed_in;
        end else if (!hold_ok) begin
            gen_steady_d = gen_steady_close_out;
        end else if (!gen_tgt_q) begin
            gen_steady_d = 1'b0;
        end else if (!gen_steady_close_out) begin
            gen_steady_d = gen_may_close;
        end
        if (ctrl_q.commutator_en) begin
            mains_steady_d = !gen_steady_d;
        end else if (mains_ext) begin
            mains_steady_d = mains_closed_in;
        end else if (!mains_tgt_q || mains_yield) begin
            mains_steady_d = 1'b0;
        end else begin
            mains_steady_d = mains_steady_close_out || mains_may_close;
        end
    end

    // Breaker state and output registers
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            mode_prev_q            <= MODE_OFF;
            man_q                  <= '0;
            gen_tgt_q              <= 1'b0;
            mains_tgt_q            <= 1'b0;
            protect_q              <= 1'b0;
            gen_steady_close_out   <= 1'b0;
            mains_steady_close_out <= 1'b0;
            gen_mv_coil_out        <= 1'b0;
            mains_mv_coil_out      <= 1'b0;
            gen_sync_active_out    <= 1'b0;
            mains_sync_active_out  <= 1'b0;
            transfer_close_out     <= 1'b0;
            mains_switch_open_out  <= 1'b0;
        end else begin
            mode_prev_q            <= ctrl_q.mode;
            man_q                  <= man_in;
            gen_tgt_q              <= gen_tgt_d;
            mains_tgt_q            <= mains_tgt_d;
            protect_q              <= mains_protect;
            gen_steady_close_out   <= gen_steady_d;
            mains_steady_close_out <= mains_steady_d;
            gen_mv_coil_out        <= gen_tgt_d || gen_closed_in;
            mains_mv_coil_out      <= mains_tgt_d || mains_closed_in;
            gen_sync_active_out    <= gen_sync_w && !gen_steady_close_out;
            mains_sync_active_out  <= mains_sync_w && !mains_steady_close_out;
            transfer_close_out     <= gen_closed_in && (immediate_supply_in ||
                                      bus_power_in >= min_pwr_q || !more_gens_in);
            mains_switch_open_out  <= !mains_tgt_d;
        end
    end

    // Second-scale timers on the shared tick
    gbc_tick_cnt u_mv_g (.clk_in(clk_in), .nrst_in(nrst_in), .run_in(gen_mv_coil_out),
                         .tick_in(tick_q), .cnt_out(mv_g_cnt));
    gbc_tick_cnt u_mv_m (.clk_in(clk_in), .nrst_in(nrst_in), .run_in(mains_mv_coil_out),
                         .tick_in(tick_q), .cnt_out(mv_m_cnt));
    gbc_tick_cnt u_both (.clk_in(clk_in), .nrst_in(nrst_in), .run_in(both_open),
                         .tick_in(tick_q), .cnt_out(both_cnt));
    gbc_tick_cnt u_hold (.clk_in(clk_in), .nrst_in(nrst_in),
                         .run_in(gen_steady_d == gen_steady_close_out),
                         .tick_in(tick_q), .cnt_out(hold_cnt));
    gbc_tick_cnt u_mopn (.clk_in(clk_in), .nrst_in(nrst_in), .run_in(man_in.mains_open),
                         .tick_in(tick_q), .cnt_out(mopen_cnt));

    // Helper: cycles the mains opening input has stayed high
    logic [31:0] hi_cyc_q;
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !man_in.mains_open) hi_cyc_q <= 32'h0;
        else if (hi_cyc_q != 32'hffffffff) hi_cyc_q <= hi_cyc_q + 32'h1;
    end

    sequence s_sync_abort;
        gen_sync_active_out ##1 !gen_tgt_q;
    endsequence

    AST_SYNC_NEEDS_REQ: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gen_sync_active_out |-> $past(gen_sync_request_in) && $past(ctrl_q.gen_use_sync))
        else $error("sync active without request");
    AST_INHIBIT_OPENS: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (is_auto && mains_closure_inhibit_in && !mains_ext && !ctrl_q.commutator_en)
        |=> !mains_tgt_q ##1 !mains_steady_close_out)
        else $error("inhibit did not open mains");
    AST_OFF_GEN_OPEN: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (is_off && !gen_ext && !ctrl_q.commutator_en) |=> !gen_tgt_q ##1 !gen_steady_close_out)
        else $error("generator not opened in off");
    AST_OFF_NO_RECLOSE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (is_off && !mains_ext && !mains_closed_in && ctrl_q.mains_coil_powered && !mains_ok_in)
        |=> !mains_tgt_q)
        else $error("mains close attempted with dead coil supply");
    AST_GEN_CLOSE_COND: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ($rose(gen_tgt_q) && !$past(gen_ext))
        |-> $past(!alarm_active_in && self_started_in && gen_ok_in))
        else $error("generator closure without conditions");
    AST_PERSIST_5S: assert property (@(posedge clk_in) disable iff (!nrst_in)
        mopen_acc |-> hi_cyc_q >= 32'((PERSIST_TICKS - 8'h01) * TICK_CYCLES))
        else $error("mains opening accepted too early");
    AST_MV_FIRST: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ($rose(gen_steady_close_out) && !$past(gen_ext))
        |-> gen_mv_coil_out && $past(mv_g_cnt) >= MV_TICKS)
        else $error("closure before coil settle");
    AST_EXT_FOLLOW: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gen_ext |=> gen_steady_close_out == $past(gen_closed_in))
        else $error("steady command not aligned to breaker");
    AST_SYNC_ABORT: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_sync_abort |=> !gen_sync_active_out && !gen_steady_close_out)
        else $error("opening did not abort synchronization");
    AST_HOLD_TIME: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ctrl_q.commutator_en && !gen_ext && $changed(gen_steady_close_out))
        |-> $past(hold_cnt) >= $past(hold_t))
        else $error("commutator reversed within holding time");
    AST_GTS_IMMEDIATE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (gen_closed_in && immediate_supply_in) |=> transfer_close_out)
        else $error("immediate supply ignored");
    AST_GTS_NEEDS_GEN: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !gen_closed_in |=> !transfer_close_out)
        else $error("transfer closed without generator");

endmodule

`default_nettype wire

/* inc/gbc_pkg.sv */
package gbc_pkg;

    // Clock and prescaled tick timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_MS       = 100;
    localparam int unsigned TICK_CYC      = TICK_MS * 1000000 / CLK_PERIOD_NS;

    // Second-scale times, in milliseconds, and their tick counts
    localparam int unsigned PERSIST_MS    = 5000;
    localparam int unsigned MV_COIL_MS    = 500;
    localparam logic [7:0]  PERSIST_TICKS = 8'(PERSIST_MS / TICK_MS);
    localparam logic [7:0]  MV_TICKS      = 8'((MV_COIL_MS + TICK_MS - 1) / TICK_MS);

    // Register byte offsets
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_TIMES     = 12'h004;
    localparam logic [11:0] REG_BUSPWR    = 12'h008;
    localparam logic [11:0] REG_CMD       = 12'h00c;
    localparam logic [11:0] REG_STATUS    = 12'h010;

    // Field layout of the times register
    localparam int unsigned TIMES_SWAP_LSB = 0;
    localparam int unsigned TIMES_HOLD_LSB = 8;

    // Reset values and the bus power limit
    localparam logic [15:0] TIMES_RST     = 16'h0a0a;
    localparam logic [14:0] BUSPWR_RST    = 15'h0000;
    localparam logic [14:0] BUSPWR_MAX    = 15'h7530;

    // Remote command codes (31, 32, 33, 41, 42, 43)
    localparam logic [7:0]  CMD_GEN_OPEN_NOW    = 8'h1f;
    localparam logic [7:0]  CMD_GEN_OPEN_UNLOAD = 8'h20;
    localparam logic [7:0]  CMD_GEN_CLOSE       = 8'h21;
    localparam logic [7:0]  CMD_MAINS_OPEN_A    = 8'h29;
    localparam logic [7:0]  CMD_MAINS_OPEN_B    = 8'h2a;
    localparam logic [7:0]  CMD_MAINS_CLOSE     = 8'h2b;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_MAN,
        MODE_AUTO
    } gbc_mode_t;

    // Control register layout, mode in the low bits
    typedef struct packed {
        logic      man_open_cfg_mains;
        logic      man_open_cfg_gen;
        logic      mains_interface;
        logic      parallel_plant;
        logic      commutator_en;
        logic      auto_man_open;
        logic      mains_use_sync;
        logic      gen_use_sync;
        logic      mains_coil_powered;
        logic      mains_timing_sel;
        gbc_mode_t mode;
    } gbc_ctrl_t;

    localparam gbc_ctrl_t CTRL_RST = '0;

    // Manual command inputs
    typedef struct packed {
        logic gen_close;
        logic gen_open;
        logic mains_close;
        logic mains_open;
    } gbc_man_t;

endpackage

/* dv/gbc_breaker_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Breaker contacts that follow the steady commands after a travel delay
module gbc_breaker_model (
    input  wire logic clk_in,
    input  wire logic gen_cmd_in,
    input  wire logic mains_cmd_in,
    output logic      gen_closed_out,
    output logic      mains_closed_out
);
    logic [2:0] gen_q   = '0;
    logic [2:0] mains_q = '0;
    // Three clocks of contact travel, so the design never sees an instant answer
    always @(posedge clk_in) begin
        gen_q   <= {gen_q[1:0], gen_cmd_in};
        mains_q <= {mains_q[1:0], mains_cmd_in};
    end
    assign gen_closed_out   = gen_q[2];
    assign mains_closed_out = mains_q[2];
endmodule
`default_nettype wire

/* dv/genset_breaker_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module genset_breaker_control_tb;
    import gbc_pkg::*;
    logic        clk_in = 0, nrst_in = 0, psel = 0, pen = 0, pwr = 0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwd = '0, prd, rd;
    logic        gcl, mcl, gok = 1, mok = 1, inh = 0, alm = 0, imm = 0, more = 1;
    logic [7:0]  misc = 8'h20;
    logic [14:0] bpw = '0, minp;
    gbc_man_t    man = '0;
    logic        rdy, slv, gsc, msc, gmv, tcl, msw, mmv, gsa, msa;
    int          num_errors = 0, cmp_count = 0, cyc = 0;
    logic [7:0]  codes [8] = '{CMD_MAINS_OPEN_A, CMD_MAINS_CLOSE, CMD_MAINS_OPEN_B,
        CMD_MAINS_CLOSE, CMD_GEN_OPEN_NOW, CMD_GEN_CLOSE, CMD_GEN_OPEN_UNLOAD, CMD_GEN_CLOSE};
    wire logic [1:0] ob = {gsc, msc};

    gbc_breaker_ctrl #(.TICK_CYCLES(4)) u_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(slv), .gen_closed_in(gcl), .mains_closed_in(mcl),
        .gen_ok_in(gok), .mains_ok_in(mok), .gen_sync_request_in(misc[0]),
        .mains_sync_request_in(misc[1]), .sync_done_in(misc[2]),
        .mains_closure_inhibit_in(inh), .gen_closure_inhibit_in(misc[3]),
        .start_request_in(misc[4]), .alarm_active_in(alm), .self_started_in(misc[5]),
        .gen_external_control_in(misc[6]), .mains_external_control_in(misc[7]),
        .man_in(man), .immediate_supply_in(imm), .more_gens_in(more), .bus_power_in(bpw),
        .gen_steady_close_out(gsc), .mains_steady_close_out(msc), .gen_mv_coil_out(gmv),
        .mains_mv_coil_out(mmv), .gen_sync_active_out(gsa), .mains_sync_active_out(msa),
        .transfer_close_out(tcl), .mains_switch_open_out(msw));
    gbc_breaker_model u_brk (.clk_in(clk_in), .gen_cmd_in(gsc), .mains_cmd_in(msc),
        .gen_closed_out(gcl), .mains_closed_out(mcl));

    // Clock and hang guard
    initial forever #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Wait boundedly for breaker command b (0 mains, 1 generator) to reach v
    task automatic wchk(input int b, input logic v);
        for (int i = 0; i < 900 && ob[b] !== v; i++) @(posedge clk_in);
        chk(ob[b], v);
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwr <= w; paddr <= a; pwd <= d;
        @(posedge clk_in) pen <= 1;
        do @(posedge clk_in); while (rdy !== 1'b1);
        rd = prd;
        err = slv;
        psel <= 0; pen <= 0;
        @(posedge clk_in);
    endtask

    function automatic logic exp_tr(input logic i, m, input logic [14:0] p, mn);
        return i | (p >= mn) | !m;
    endfunction

    // Main sequence
    initial begin
        rd = $urandom(55871);
        repeat (5) @(posedge clk_in);
        nrst_in <= 1;
        @(posedge clk_in);
        apb(0, REG_TIMES, 0);
        chk(rd, 32'h0000_0a0a);
        apb(0, 12'h0fc, 0);
        chk({rd[30:0], err}, 32'h0000_0001);
        wchk(0, 1);
        wchk(1, 0);
        apb(1, REG_CTRL, 32'h0000_000c);
        mok <= 0;
        wchk(0, 0);
        chk(msw, 1);
        repeat (100) @(posedge clk_in);
        chk(msc, 0);
        mok <= 1;
        wchk(0, 1);
        // Automatic mode: inhibit inputs, start request, then drop to manual
        misc <= 8'h38;
        inh <= 1;
        apb(1, REG_CTRL, 32'h0000_0042);
        wchk(0, 0);
        wchk(1, 0);
        misc <= 8'h30;
        inh <= 0;
        wchk(1, 1);
        apb(1, REG_CTRL, 32'h0000_0041);
        wchk(1, 0);
        misc <= 8'h20;
        for (int k = 0; k < 2; k++) begin
            {alm, gok} <= k ? 2'b00 : 2'b11;
            apb(1, REG_CMD, {24'h0, CMD_GEN_CLOSE});
            repeat (200) @(posedge clk_in);
            chk(gsc, 0);
        end
        {alm, gok} <= 2'b01;
        // Manual mains opening input must persist; closure input edge recloses
        apb(1, REG_CTRL, 32'h0000_0801);
        apb(1, REG_CMD, {24'h0, CMD_MAINS_CLOSE});
        wchk(0, 1);
        man <= 4'h1;
        repeat (150) @(posedge clk_in);
        chk(msc, 1);
        repeat (120) @(posedge clk_in);
        chk(msc, 0);
        man <= 4'h2;
        wchk(0, 1);
        foreach (codes[k]) begin
            apb(1, REG_CMD, {24'h0, codes[k]});
            wchk(int'(codes[k] < 8'h29), codes[k] inside {CMD_GEN_CLOSE, CMD_MAINS_CLOSE});
        end
        chk(gmv, 1);
        chk(mmv, 1);
        chk(msa, 0);
        repeat (20) begin
            minp = 15'($urandom_range(30000));
            apb(1, REG_BUSPWR, {17'h0, minp});
            {imm, more} <= 2'($urandom);
            bpw <= 15'($urandom);
            repeat (3) @(posedge clk_in);
            chk(tcl, exp_tr(imm, more, bpw, minp));
        end
        // Synchronized generator closure, request drop and abort
        apb(1, REG_CTRL, 32'h0000_0811);
        apb(1, REG_CMD, {24'h0, CMD_GEN_OPEN_NOW});
        wchk(1, 0);
        wchk(0, 1);
        misc <= 8'h21;
        apb(1, REG_CMD, {24'h0, CMD_GEN_CLOSE});
        repeat (10) @(posedge clk_in);
        chk(gsa, 1);
        chk(gsc, 0);
        misc <= 8'h20;
        repeat (3) @(posedge clk_in);
        chk(gsa, 0);
        misc <= 8'h21;
        repeat (3) @(posedge clk_in);
        chk(gsa, 1);
        apb(1, REG_CMD, {24'h0, CMD_GEN_OPEN_NOW});
        repeat (3) @(posedge clk_in);
        chk({gsa, gsc}, 0);
        apb(1, REG_CMD, {24'h0, CMD_GEN_CLOSE});
        misc <= 8'h25;
        wchk(1, 1);
        repeat (3) @(posedge clk_in);
        chk(gsa, 0);
        // External control freezes the generator breaker
        misc <= 8'h65;
        apb(1, REG_CMD, {24'h0, CMD_GEN_OPEN_NOW});
        repeat (20) @(posedge clk_in);
        chk(gsc, 1);
        misc <= 8'h25;
        // Commutator: steady command moves loads, reversal held off
        apb(1, REG_TIMES, 32'h0000_140a);
        apb(1, REG_CTRL, 32'h0000_0081);
        apb(1, REG_CMD, {24'h0, CMD_GEN_OPEN_NOW});
        wchk(1, 0);
        chk(msc, 1);
        apb(1, REG_CMD, {24'h0, CMD_GEN_CLOSE});
        repeat (40) @(posedge clk_in);
        chk(gsc, 0);
        wchk(1, 1);
        chk(msc, 0);
        complete_run();
    end
endmodule
`default_nettype wire
